// [fsp_core_model.sv]
module fsp_core_model
    import fsp_pkg::*;
(
    input  wire logic      clock_in,
    output fsp_store_req_t store_req_out,
    output fsp_load_req_t  load_req_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        store_req_out = '0;
        load_req_out  = '0;
    end

    // Store instruction issued from boot code, one cycle wide
    task automatic store(input logic [15:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clock_in);
        store_req_out <= '{1'b1, a, lo, hi, 1'b1};
        @(posedge clock_in);
        // Operands go stale at once, as on a real core
        store_req_out <= '{1'b0, ~a, ~lo, ~hi, 1'b1};
    endtask

    // Load instruction from boot code; address held for the blocking check
    task automatic load(input logic [15:0] a);
        @(posedge clock_in);
        load_req_out <= '{1'b1, a, 1'b1};
        @(posedge clock_in);
        load_req_out <= '{1'b0, a, 1'b1};
    endtask
endmodule // fsp_core_model

// [fsp_flash_control.sv]
// Function
// RULE1 - Lock bits only go programmed by software; clearing needs chip erase; code also clears them to LOCKS_RESET on system reset.
// RULE2 - General memory lock modes never restrict store or load program access.
// RULE3 - Application field: 10 blocks stores, 00 stores and boot loads, 01 loads.
// RULE4 - App modes 3,4 with boot vectors: mask interrupts while running application code.
// RULE5 - Boot field: 10 blocks stores, 00 stores and app loads, 01 loads.
// RULE6 - Boot modes 3,4 with app vectors: mask interrupts while running boot code.
// RULE7 - Reset vector is 0000 when fuse is 1, boot start when 0.
// RULE8 - Processor can never alter fuses; only external programming can.
// RULE9 - Control register 8 bits, reset zero, bit6 busy read-only, bit5 zero.
// RULE10 - Ready interrupt requested continuously while enabled, global flag set, store-enable low.
// RULE11 - Erase or write to read-while-write section sets busy and blocks that section.
// RULE12 - Busy clears on re-enable command after programming or on buffer load start.
// RULE13 - Re-enable plus store within four cycles; refused while erase or write runs.
// RULE14 - Re-enable written during buffer loading aborts and discards buffered data.
// RULE15 - Lock-set store programs boot locks from low working register; auto-clears.
// RULE16 - Load within three cycles of lock-set returns locks or fuses by pointer bit0.
// RULE17 - Page-write stores buffer to upper pointer page; halts CPU on protected section; code halts on no-read-while-write section.
// RULE18 - Page-erase erases upper pointer page, ignoring data registers; auto-clears.
// RULE19 - Store-enable alone loads working word into buffer, pointer bit0 ignored.
// RULE20 - Store-enable clears after store or four idle cycles; holds during programming.
// RULE21 - Only five command patterns act; any other pattern is ignored.
// RULE22 - Page buffer clears after page write, re-enable, and system reset.
// RULE23 - Erase or write into store-protected section is suppressed; command bits clear.
// RULE24 - Window starts after register write, down-counter clears command bits on expiry.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
module fsp_flash_control
    import fsp_pkg::*;
#(
    parameter int          PAGE_WORDS  = 64,
    parameter int          PAGE_BITS   = 6,
    parameter int          PROG_CYCLES = PROG_CYCLES_DEF,
    parameter logic [15:0] BOOT_START  = 16'h3800,
    parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_START  = 16'h3800
) (
    input  wire logic            clock_in,
    input  wire logic            resetn_in,
    input  wire logic [3:0]      avs_address_in,
    input  wire logic            avs_read_in,
    input  wire logic            avs_write_in,
    input  wire logic [31:0]     avs_writedata_in,
    input  wire logic [3:0]      avs_byteenable_in,
    output logic [31:0]          avs_readdata_out,
    output logic                 avs_waitrequest_out,
    input  wire fsp_store_req_t  store_req_in,
    input  wire fsp_load_req_t   load_req_in,
    output logic [7:0]           load_data_out,
    output logic                 load_special_out,
    output logic                 load_blocked_out,
    input  wire logic            global_irq_en_in,
    input  wire logic            vectors_in_boot_in,
    input  wire logic            exec_from_boot_in,
    input  wire logic [7:0]      fuse_bits_in,
    input  wire logic            chip_erase_in,
    output logic                 irq_mask_out,
    output logic                 ready_irq_out,
    output logic                 cpu_halt_out,
    output logic                 section_blocked_out,
    output logic [15:0]          reset_vector_out,
    output logic                 flash_erase_out,
    output logic                 flash_write_out,
    output logic [15:0]          flash_page_addr_out,
    output logic [15:0]          flash_wdata_out,
    output logic [PAGE_BITS-1:0] flash_word_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        fsp_state_e_t         st;
        logic [7:0]           ctl;
        logic [2:0]           window;
        logic [2:0]           load_win;
        logic [31:0]          prog_cnt;
        logic                 prog_no_read_while_write_section;
        logic [3:0]           locks;
        logic                 loading;
        logic [PAGE_WORDS-1:0] valid;
        logic                 ack;
        logic [31:0]          rdata;
        logic [7:0]           ldata;
        logic                 lspec;
        logic                 erase;
        logic                 wr;
        logic [15:0]          page;
        logic [15:0]          wdata;
        logic [PAGE_BITS-1:0] word;
        logic [PAGE_BITS:0]   wptr;
    } fsp_regs_t;

    fsp_regs_t r;
    fsp_regs_t next_r;
    logic [15:0] buf_mem [PAGE_WORDS];
    logic        buf_we;
    logic [PAGE_BITS-1:0] buf_idx;
    logic [PAGE_BITS-1:0] wr_idx;
    logic        app_no_store;
    logic        app_no_load;
    logic        boot_no_store;
    logic        boot_no_load;
    logic        tgt_boot;
    logic        acc_ctl;
    logic [4:0]  cmd;
    logic [7:0]  wbyte;

    // ************************************************************
    // Protection decode (general lock modes have no input here)
    // ************************************************************
    assign app_no_store  = ~r.locks[0];                              // RULE3 RULE2
    assign app_no_load   = ~r.locks[1];                              // RULE3
    assign boot_no_store = ~r.locks[2];                              // RULE5
    assign boot_no_load  = ~r.locks[3];                              // RULE5
    assign tgt_boot      = store_req_in.addr[15:1] >= BOOT_START[15:1];

    always_comb begin
        // Loads across sections only; each side reads itself freely
        if (load_req_in.addr >= BOOT_START) begin
            load_blocked_out = ~load_req_in.from_boot & boot_no_load;   // RULE5
        end else begin
            load_blocked_out = load_req_in.from_boot & app_no_load;     // RULE3
        end
        // Busy covers the whole read-while-write section, not one lock field
        if (r.ctl[CTL_BUSY_BIT] && load_req_in.addr < NO_READ_WHILE_WRITE_SECTION_START) begin
            load_blocked_out = 1'b1;                                    // RULE11
        end
    end

    // Modes 3 and 4 share bit hi programmed
    assign irq_mask_out = (~r.locks[1] & vectors_in_boot_in & ~exec_from_boot_in)   // RULE4
                        | (~r.locks[3] & ~vectors_in_boot_in & exec_from_boot_in);  // RULE6
    assign ready_irq_out = r.ctl[CTL_IRQ_EN_BIT] & global_irq_en_in
                         & ~r.ctl[CTL_STEN_BIT];                                    // RULE10
    // Fuse is an input only; nothing here can write it
    assign reset_vector_out = fuse_bits_in[0] ? 16'h0000 : BOOT_START;              // RULE7 RULE8
    assign section_blocked_out = r.ctl[CTL_BUSY_BIT];                               // RULE11
    assign cpu_halt_out = (r.st == FSP_PROG) & r.prog_no_read_while_write_section;                         // RULE17

    assign acc_ctl = avs_address_in == REG_CONTROL_OFS;
    assign wbyte   = avs_writedata_in[7:0];
    assign cmd     = wbyte[4:0];
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~r.ack;
    assign avs_readdata_out    = r.rdata;
    assign load_data_out       = r.ldata;
    assign load_special_out    = r.lspec;
    assign flash_erase_out     = r.erase;
    assign flash_write_out     = r.wr;
    assign flash_page_addr_out = r.page;
    assign flash_wdata_out     = r.wdata;
    assign flash_word_out      = r.word;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_r        = r;
        next_r.ack    = 1'b0;
        next_r.erase  = 1'b0;
        next_r.wr     = 1'b0;
        next_r.lspec  = 1'b0;
        buf_we        = 1'b0;
        buf_idx       = store_req_in.addr[PAGE_BITS:1];                // RULE19
        wr_idx        = r.wptr[PAGE_BITS-1:0];
        if (chip_erase_in) begin
            next_r.locks = LOCKS_RESET;                                 // RULE1
        end
        if (r.load_win != 3'h0) begin
            next_r.load_win = r.load_win - 3'h1;
        end
        if ((avs_read_in | avs_write_in) & ~r.ack) begin
            next_r.ack = 1'b1;
            case (avs_address_in)
                REG_CONTROL_OFS: next_r.rdata = {24'h0, r.ctl & 8'hDF};     // RULE9
                REG_LOCKS_OFS:   next_r.rdata = {24'h0, 2'b11, r.locks, 2'b11};
                REG_FUSE_OFS:    next_r.rdata = {24'h0, fuse_bits_in};
                REG_STATUS_OFS:  next_r.rdata = {30'h0, r.loading, r.st == FSP_PROG};
                default:         next_r.rdata = 32'h0;
            endcase
        end
        case (r.st)
            FSP_IDLE, FSP_ARMED: begin
                if (r.st == FSP_ARMED) begin
                    next_r.window = r.window - 3'h1;                         // RULE24
                    if (r.window == 3'h1) begin
                        next_r.ctl[4:0] = 5'h00;                             // RULE20 RULE24
                        next_r.st       = FSP_IDLE;
                    end
                end
                if (r.st == FSP_ARMED && store_req_in.start) begin
                    next_r.ctl[4:0] = 5'h00;                                 // RULE20
                    next_r.st       = FSP_IDLE;
                    case (r.ctl[4:0])
                        CMD_BUFLOAD: begin
                            buf_we              = 1'b1;                      // RULE19
                            next_r.loading      = 1'b1;
                            next_r.valid[buf_idx] = 1'b1;
                            next_r.ctl[CTL_BUSY_BIT] = 1'b0;                 // RULE12
                        end
                        CMD_REENABLE: begin
                            next_r.ctl[CTL_BUSY_BIT] = 1'b0;                 // RULE12 RULE13
                            next_r.valid   = '0;                             // RULE14 RULE22
                            next_r.loading = 1'b0;
                        end
                        CMD_LOCKSET: begin
                            // Ones never unprogram a lock bit
                            next_r.locks = r.locks & store_req_in.low_data[5:2];  // RULE15 RULE1
                        end
                        CMD_PGERASE, CMD_PGWRITE: begin
                            next_r.page      = {store_req_in.addr[15:PAGE_BITS+1],
                                                {(PAGE_BITS+1){1'b0}}};       // RULE17 RULE18
                            next_r.prog_no_read_while_write_section = store_req_in.addr >= NO_READ_WHILE_WRITE_SECTION_START;
                            next_r.wptr      = '0;
                            if ((tgt_boot & boot_no_store)
                                    | (~tgt_boot & app_no_store)) begin
                                next_r.ctl[4:0] = 5'h00;                     // RULE23
                            end else begin
                                next_r.ctl[4:0] = r.ctl[4:0];                // RULE20
                                next_r.st       = FSP_PROG;
                                next_r.prog_cnt = 32'(PROG_CYCLES);
                                if (store_req_in.addr < NO_READ_WHILE_WRITE_SECTION_START) begin
                                    next_r.ctl[CTL_BUSY_BIT] = 1'b1;         // RULE11
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (r.st == FSP_ARMED && load_req_in.start && r.load_win != 3'h0
                        && r.ctl[4:0] == CMD_LOCKSET) begin
                    next_r.lspec = 1'b1;                                     // RULE16
                    next_r.ldata = load_req_in.addr[0] ? fuse_bits_in
                                 : {2'b11, r.locks, 2'b11};
                end
                if (avs_write_in & ~r.ack & acc_ctl & avs_byteenable_in[0]) begin
                    next_r.ctl[CTL_IRQ_EN_BIT] = wbyte[CTL_IRQ_EN_BIT];
                    if (cmd == CMD_BUFLOAD || cmd == CMD_LOCKSET
                            || cmd == CMD_PGWRITE || cmd == CMD_PGERASE
                            || cmd == CMD_REENABLE) begin                    // RULE21
                        next_r.ctl[4:0] = cmd;
                        next_r.st       = FSP_ARMED;
                        next_r.window   = WINDOW_CYCLES;                     // RULE24
                        next_r.load_win = LOAD_CYCLES;
                        if (cmd == CMD_REENABLE && r.loading) begin
                            next_r.valid   = '0;                             // RULE14
                            next_r.loading = 1'b0;
                        end
                    end
                end
            end
            FSP_PROG: begin
                // Store-enable and command stay high until the array is done
                if (avs_write_in & ~r.ack & acc_ctl & avs_byteenable_in[0]) begin
                    next_r.ctl[CTL_IRQ_EN_BIT] = wbyte[CTL_IRQ_EN_BIT];      // RULE13
                end
                if (r.ctl[CTL_PGWR_BIT]) begin
                    // Page is cut short if PROG_CYCLES is below PAGE_WORDS
                    if (r.wptr != (PAGE_BITS+1)'(PAGE_WORDS)) begin
                        next_r.wr    = 1'b1;                                 // RULE17
                        next_r.word  = wr_idx;
                        next_r.wdata = r.valid[wr_idx] ? buf_mem[wr_idx] : 16'hFFFF;
                        next_r.wptr  = r.wptr + (PAGE_BITS+1)'(1);
                    end
                end else begin
                    next_r.erase = r.prog_cnt == 32'(PROG_CYCLES);           // RULE18
                end
                next_r.prog_cnt = r.prog_cnt - 32'h1;
                if (r.prog_cnt == 32'h1) begin
                    next_r.st       = FSP_IDLE;
                    next_r.ctl[4:0] = 5'h00;                                 // RULE20
                    if (r.ctl[CTL_PGWR_BIT]) begin
                        next_r.valid   = '0;                                 // RULE22
                        next_r.loading = 1'b0;
                    end
                end
            end
            default: next_r.st = FSP_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r       <= '0;
            r.st    <= FSP_IDLE;
            r.ctl   <= CONTROL_RESET;                                        // RULE9
            r.locks <= LOCKS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Buffer words; reset clears only the valid map
    always_ff @(posedge clock_in) begin
        if (buf_we) begin
            buf_mem[buf_idx] <= {store_req_in.high_data, store_req_in.low_data};
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence armed_write_s;
        avs_write_in && !r.ack && acc_ctl && avs_byteenable_in[0] && cmd == CMD_BUFLOAD
            && r.st != FSP_PROG;
    endsequence

    sequence idle_four_s;
        !store_req_in.start [*4];
    endsequence

    ctl_reset_a: assert property (@(posedge clock_in) !resetn_in |=> r.ctl == 8'h00) // RULE9
        else $error("control not zero after reset");
    reserved_bit_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE9
        r.ack && acc_ctl |-> !avs_readdata_out[5])
        else $error("reserved bit read one");
    irq_level_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE10
        ready_irq_out == (r.ctl[7] && global_irq_en_in && !r.ctl[0]))
        else $error("ready interrupt wrong");
    window_exp_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE20 RULE24
        armed_write_s ##1 idle_four_s |=> r.ctl[0] == 1'b0)
        else $error("store enable not cleared after window");
    bad_cmd_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE21
        avs_write_in && !r.ack && acc_ctl && r.st == FSP_IDLE && cmd == 5'h1F
        |=> r.ctl[4:0] == 5'h00)
        else $error("illegal command took effect");
    prog_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE20 RULE13
        r.st == FSP_PROG && r.prog_cnt > 32'h1 |=> r.ctl[0])
        else $error("store enable dropped during programming");
    lock_keep_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE1
        !chip_erase_in |=> (r.locks & ~$past(r.locks)) == 4'h0)
        else $error("lock bit unprogrammed by software");
    fuse_vec_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE7
        fuse_bits_in[0] |-> reset_vector_out == 16'h0000)
        else $error("reset vector wrong");
    busy_block_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE11
        r.ctl[6] && load_req_in.addr < NO_READ_WHILE_WRITE_SECTION_START |-> load_blocked_out)
        else $error("busy section readable");
    protect_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE23
        r.st == FSP_ARMED && store_req_in.start && r.ctl[4:0] == CMD_PGERASE
        && !tgt_boot && app_no_store |=> r.st == FSP_IDLE && !r.erase)
        else $error("protected erase started");

    sequence armed_store_s;
        r.st == FSP_ARMED && store_req_in.start;
    endsequence

    rww_write_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE11 RULE17
        armed_store_s ##0 (r.ctl[4:0] == CMD_PGWRITE && store_req_in.addr < NO_READ_WHILE_WRITE_SECTION_START
        && !app_no_store && !tgt_boot) |=> section_blocked_out && !cpu_halt_out)
        else $error("write start busy or halt wrong");

    reenable_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE12 RULE13
        armed_store_s ##0 (r.ctl[4:0] == CMD_REENABLE) |=> !section_blocked_out)
        else $error("busy kept after re-enable");

    buf_load_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE19 RULE12
        armed_store_s ##0 (r.ctl[4:0] == CMD_BUFLOAD) |=> r.loading && !section_blocked_out)
        else $error("buffer load not started");

    lock_read_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE16
        r.st == FSP_ARMED && r.ctl[4:0] == CMD_LOCKSET && load_req_in.start
        && r.load_win != 3'h0 |=> load_special_out)
        else $error("lock read not returned");

    word_start_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE17
        r.st == FSP_PROG && r.ctl[CTL_PGWR_BIT] && r.wptr == '0
        |=> flash_write_out && flash_word_out == '0)
        else $error("page write not from word zero");

    buf_clear_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // RULE22
        r.st == FSP_PROG && r.ctl[CTL_PGWR_BIT] && r.prog_cnt == 32'h1
        |=> r.valid == '0)
        else $error("page buffer kept after write");

endmodule // fsp_flash_control

// [fsp_pkg.sv]
package fsp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] REG_CONTROL_OFS  = 4'h0;
    localparam logic [3:0] REG_LOCKS_OFS    = 4'h4;
    localparam logic [3:0] REG_FUSE_OFS     = 4'h8;
    localparam logic [3:0] REG_STATUS_OFS   = 4'hC;
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [3:0] LOCKS_RESET      = 4'hF;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTL_IRQ_EN_BIT  = 7;
    localparam int CTL_BUSY_BIT    = 6;
    localparam int CTL_REEN_BIT    = 4;
    localparam int CTL_LOCK_BIT    = 3;
    localparam int CTL_PGWR_BIT    = 2;
    localparam int CTL_PGER_BIT    = 1;
    localparam int CTL_STEN_BIT    = 0;

    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCKSET  = 5'h09;
    localparam logic [4:0] CMD_PGWRITE  = 5'h05;
    localparam logic [4:0] CMD_PGERASE  = 5'h03;
    localparam logic [4:0] CMD_BUFLOAD  = 5'h01;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_NS          = 25;
    localparam int          STORE_WINDOW    = 4;
    localparam int          LOAD_WINDOW     = 3;
    localparam logic [2:0]  WINDOW_CYCLES   = 3'(STORE_WINDOW);
    localparam logic [2:0]  LOAD_CYCLES     = 3'(LOAD_WINDOW);
    localparam int          PROG_TIME_NS    = 4000000;
    localparam int          PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_PROG
    } fsp_state_e_t;

    typedef struct packed {
        logic                 start;
        logic [15:0]          addr;
        logic [7:0]           low_data;
        logic [7:0]           high_data;
        logic                 from_boot;
    } fsp_store_req_t;

    typedef struct packed {
        logic                 start;
        logic [15:0]          addr;
        logic                 from_boot;
    } fsp_load_req_t;

endpackage

// [fsp_testbench.sv]
module testbench;
    import fsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clock_in, resetn_in, av_rd, av_wr, gie, av_wait, rdy, busy, fl_er, fl_wr;
    logic [3:0]     av_addr;
    logic [31:0]    av_wd, av_rdata, q;
    logic [7:0]     fuse, ldata;
    logic           lspec, blk;
    logic [15:0]    rvec, wdata, cap;
    logic [5:0]     word;
    int             error_cnt, cmp_count, erase_cnt;
    fsp_store_req_t st_req;
    fsp_load_req_t  ld_req;
    logic [7:0]     row_wr  [5] = '{8'h1F, 8'h81, 8'h09, 8'h03, 8'hE0};
    logic [7:0]     row_exp [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h80};

    fsp_flash_control #(.PROG_CYCLES(80)) fsp_flash_control_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
        .store_req_in(st_req), .load_req_in(ld_req), .load_data_out(ldata),
        .load_special_out(lspec), .load_blocked_out(blk), .global_irq_en_in(gie),
        .vectors_in_boot_in(1'b1),
        .exec_from_boot_in(1'b1), .fuse_bits_in(fuse), .chip_erase_in(1'b0),
        .irq_mask_out(), .ready_irq_out(rdy), .cpu_halt_out(), .section_blocked_out(busy),
        .reset_vector_out(rvec), .flash_erase_out(fl_er), .flash_write_out(fl_wr),
        .flash_page_addr_out(), .flash_wdata_out(wdata), .flash_word_out(word));

    fsp_core_model fsp_core_model_inst (.clock_in(clock_in), .store_req_out(st_req),
        .load_req_out(ld_req));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        if (fl_er === 1'b1) erase_cnt++;
        if (fl_wr === 1'b1 && word === 6'h01) cap <= wdata;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic report_and_stop;
        $display("Counts: errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        av_wr <= wr;
        av_rd <= ~wr;
        av_addr <= a;
        av_wd <= {24'h0, d};
        do begin
            @(posedge clock_in);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic cmd(input logic [4:0] c, input logic [15:0] a, input logic [7:0] lo);
        bus(1'b1, REG_CONTROL_OFS, {3'h0, c});
        fsp_core_model_inst.store(a, lo, 8'h12);
    endtask

    // Polls store-enable; bound covers the shortened programming time
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_CONTROL_OFS, 8'h00);
            n++;
        end while (q[0] !== 1'b0 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        erase_cnt = 0;
        cap = 16'h0000;
        resetn_in = 1'b0;
        {av_rd, av_wr, av_addr, av_wd} = '0;
        gie = 1'b1;
        fuse = 8'hFF;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        bus(1'b0, REG_CONTROL_OFS, 8'h00);
        chk("control reset", {8'h00, CONTROL_RESET}, q[15:0]);
        bus(1'b0, REG_LOCKS_OFS, 8'h00);
        chk("locks reset", 16'h00FF, q[15:0]);
        bus(1'b0, 4'h2, 8'h00);
        chk("unmapped read", 16'h0000, q[15:0]);
        chk("reset vector app", 16'h0000, rvec);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, REG_CONTROL_OFS, row_wr[i]);
            repeat (8) @(posedge clock_in);
            bus(1'b0, REG_CONTROL_OFS, 8'h00);
            chk("control row", {8'h00, row_exp[i]}, q[15:0]);
            chk("ready irq", {15'h0, row_exp[i][7]}, {15'h0, rdy});
        end
        cmd(CMD_PGERASE, 16'h0100, 8'hAA);
        bus(1'b0, REG_CONTROL_OFS, 8'h00);
        chk("busy during erase", 16'h0043, q[15:0]);
        chk("section blocked", 16'h0001, {15'h0, busy});
        wait_done();
        chk("erase pulses", 16'h0001, 16'(erase_cnt));
        cmd(CMD_REENABLE, 16'h0000, 8'h00);
        repeat (8) @(posedge clock_in);
        chk("busy after reenable", 16'h0000, {15'h0, busy});
        cmd(CMD_BUFLOAD, 16'h0103, 8'h34);
        cmd(CMD_PGWRITE, 16'h0100, 8'h00);
        wait_done();
        chk("written word", 16'h1234, cap);
        cmd(CMD_LOCKSET, 16'h0000, 8'hF3);
        wait_done();
        bus(1'b0, REG_LOCKS_OFS, 8'h00);
        chk("locks programmed", 16'h00F3, q[15:0]);
        bus(1'b1, REG_CONTROL_OFS, {3'h0, CMD_LOCKSET});
        fsp_core_model_inst.load(16'h0100);
        @(posedge clock_in);
        chk("lock read", 16'h01F3, {7'h0, lspec, ldata});
        chk("load blocked", 16'h0001, {15'h0, blk});
        cmd(CMD_PGERASE, 16'h0100, 8'h00);
        wait_done();
        chk("protected erase", 16'h0001, 16'(erase_cnt));
        fuse <= 8'hFE;
        repeat (2) @(posedge clock_in);
        chk("reset vector boot", 16'h3800, rvec);
        report_and_stop();
    end
endmodule // testbench
